// ===== hw/nac_top.sv
// Implementation choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module nac_top #(
  parameter int unsigned WRITE_CYCLES = nac_pkg::WRITE_CYCLES,
  parameter int ADDR_W = 8
) (
  // Clock and resets.
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic MASTER_CLEAR_PIN_RST_IN,
  input wire logic WATCHDOG_TIMEOUT_RST_IN,
  // AHB-Lite slave.
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  // Program flash and configuration array side.
  output nac_pkg::nac_flash_req_s FLASH_REQ_OUT,
  output logic CPU_STALL_OUT
);

  // Phase length: the write is split into an erase half and a program half.
  localparam int unsigned PHASE_CYCLES = (WRITE_CYCLES / 2 > 0) ? WRITE_CYCLES / 2 : 1;
  localparam logic [31:0] PHASE_LAST = 32'(PHASE_CYCLES - 1);

  // Warm resets keep the abort flag; power-up reset clears every register but the EEPROM array, HRESP_OUT (not reset) and HREADYOUT_OUT (set to 1).
  logic warm_rst;
  logic any_rst;
  assign warm_rst = MASTER_CLEAR_PIN_RST_IN | WATCHDOG_TIMEOUT_RST_IN;
  assign any_rst = RST_IN | warm_rst;

  // Data EEPROM array; nonvolatile, so it is never reset.
  logic [7:0] eeprom_mem [0:(1 << ADDR_W) - 1];

  // Captured address phase.
  logic ap_valid_r;
  logic ap_write_r;
  logic [7:0] ap_addr_r;

  // Control register fields.
  logic program_sel_r;
  logic config_sel_r;
  logic erase_only_r;
  logic abort_flag_r;
  logic modify_permit_r;
  logic program_go_r;
  logic fetch_go_r;

  // Other software-visible registers.
  logic [ADDR_W-1:0] nvm_address_r;
  logic [7:0] nvm_data_byte_r;
  logic [7:0] table_latch_r;
  logic [20:0] table_pointer_r;
  logic done_flag_r;

  // Sequencer state.
  nac_pkg::nac_state_e state_r;
  nac_pkg::nac_unlock_e unlock_r;
  logic [31:0] timer_r;
  logic job_flash_r;

  // Bus-side strobes.
  logic bus_wr;
  logic [7:0] wdata;
  logic ctrl_wr;
  logic start_ok;
  logic fetch_ok;
  logic phase_end;
  logic write_finish;
  logic read_pending_r;

  assign wdata = HWDATA_IN[7:0];
  assign bus_wr = ap_valid_r & ap_write_r;
  assign ctrl_wr = bus_wr & (ap_addr_r == nac_pkg::OFS_CONTROL);
  assign phase_end = (state_r != nac_pkg::ST_IDLE) & (timer_r == PHASE_LAST);
  assign write_finish = phase_end & (state_r == nac_pkg::ST_PROGRAM);

  // A start is honoured only with permission and a fresh unlock, and never
  // while another operation runs; improper attempts are simply dropped.
  // unlock gate start
  assign start_ok = ctrl_wr & wdata[nac_pkg::BIT_PROGRAM_GO] & ~program_go_r & ~fetch_go_r
                    & modify_permit_r & (unlock_r == nac_pkg::UL_ARMED);

  // A read may only start towards the data EEPROM; the select bits written in
  // the same access count, so one write can select and start together.
  // refuse program reads
  assign fetch_ok = ctrl_wr & wdata[nac_pkg::BIT_FETCH_GO] & ~wdata[nac_pkg::BIT_PROGRAM_SEL]
                    & ~wdata[nac_pkg::BIT_CONFIG_SEL] & (state_r == nac_pkg::ST_IDLE);

  // Address phase capture; only single word transfers are expected.
  always_ff @(posedge CLK_IN) begin
    if (any_rst) begin
      ap_valid_r <= 1'b0;
      ap_write_r <= 1'b0;
      ap_addr_r <= nac_pkg::RESET_BYTE;
    end else if (HREADY_IN) begin
      ap_valid_r <= HSEL_IN & HTRANS_IN[1];
      ap_write_r <= HWRITE_IN;
      ap_addr_r <= HADDR_IN[7:0];
    end
  end

  // Reads take one wait state, so a write landing just before is visible.
  always_ff @(posedge CLK_IN) begin
    if (any_rst) begin
      read_pending_r <= 1'b0;
      HREADYOUT_OUT <= 1'b1;
    end else begin
      read_pending_r <= HREADY_IN & HSEL_IN & HTRANS_IN[1] & ~HWRITE_IN;
      HREADYOUT_OUT <= ~(HREADY_IN & HSEL_IN & HTRANS_IN[1] & ~HWRITE_IN);
    end
  end

  // The response is always OKAY.
  always_ff @(posedge CLK_IN) begin
    HRESP_OUT <= 1'b0;
  end

  // Read data mux; unmapped offsets return zero.
  always_ff @(posedge CLK_IN) begin
    if (any_rst) begin
      HRDATA_OUT <= 32'h00000000;
    end else if (read_pending_r) begin
      unique case (ap_addr_r)
        nac_pkg::OFS_CONTROL: HRDATA_OUT <= {24'h000000, program_sel_r, config_sel_r, 1'b0, erase_only_r,
                                             abort_flag_r, modify_permit_r, program_go_r, fetch_go_r};
        nac_pkg::OFS_UNLOCK: HRDATA_OUT <= 32'h00000000;
        nac_pkg::OFS_DATA_BYTE: HRDATA_OUT <= {24'h000000, nvm_data_byte_r};
        nac_pkg::OFS_ADDRESS: HRDATA_OUT <= {24'h000000, nvm_address_r};
        nac_pkg::OFS_TABLE_LATCH: HRDATA_OUT <= {24'h000000, table_latch_r};
        nac_pkg::OFS_TPTR_LOW: HRDATA_OUT <= {24'h000000, table_pointer_r[7:0]};
        nac_pkg::OFS_TPTR_HIGH: HRDATA_OUT <= {24'h000000, table_pointer_r[15:8]};
        nac_pkg::OFS_TPTR_UPPER: HRDATA_OUT <= {27'h0000000, table_pointer_r[20:16]};
        nac_pkg::OFS_FLAGS_TWO: HRDATA_OUT <= {27'h0000000, done_flag_r, 4'h0};
        default: HRDATA_OUT <= 32'h00000000;
      endcase
    end
  end

  // Unlock tracker: 55h then AAh arms it; any other write disarms it, so
  // the start must be the very next write after the two keys.
  // track key order
  always_ff @(posedge CLK_IN) begin
    if (any_rst) begin
      unlock_r <= nac_pkg::UL_NONE;
    end else if (bus_wr) begin
      if (ap_addr_r == nac_pkg::OFS_UNLOCK && wdata == nac_pkg::UNLOCK_KEY_FIRST) begin
        unlock_r <= nac_pkg::UL_FIRST;
      end else if (ap_addr_r == nac_pkg::OFS_UNLOCK && wdata == nac_pkg::UNLOCK_KEY_SECOND
                   && unlock_r == nac_pkg::UL_FIRST) begin
        unlock_r <= nac_pkg::UL_ARMED;
      end else begin
        unlock_r <= nac_pkg::UL_NONE;
      end
    end
  end

  // Plain control bits written by software.
  // program space select
  always_ff @(posedge CLK_IN) begin
    if (any_rst) begin
      program_sel_r <= 1'b0;
      config_sel_r <= 1'b0;
      erase_only_r <= 1'b0;
      modify_permit_r <= 1'b0;
    end else if (ctrl_wr) begin
      program_sel_r <= wdata[nac_pkg::BIT_PROGRAM_SEL];
      config_sel_r <= wdata[nac_pkg::BIT_CONFIG_SEL];
      erase_only_r <= wdata[nac_pkg::BIT_ERASE_ONLY];
      modify_permit_r <= wdata[nac_pkg::BIT_MODIFY_PERMIT];
    end
  end

  // Abort flag: of the resets, only power-up reset clears it. A warm reset leaves it as it
  // stands, so a write cut short keeps the 1 set at its start.
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      abort_flag_r <= 1'b0;
    end else if (warm_rst) begin
      abort_flag_r <= abort_flag_r;
    end else if (start_ok) begin
      abort_flag_r <= 1'b1;
    end else if (write_finish) begin
      abort_flag_r <= 1'b0;
    end else if (ctrl_wr) begin
      abort_flag_r <= wdata[nac_pkg::BIT_ABORT_FLAG];
    end
  end

  // Write start bit: software can only set it; hardware clears it.
  // set only, hardware clears
  always_ff @(posedge CLK_IN) begin
    if (any_rst) begin
      program_go_r <= 1'b0;
    end else if (start_ok) begin
      program_go_r <= 1'b1;
    end else if (write_finish) begin
      program_go_r <= 1'b0;
    end
  end

  // Read start bit: set by software, cleared one cycle later by hardware.
  // read start and clear
  always_ff @(posedge CLK_IN) begin
    if (any_rst) begin
      fetch_go_r <= 1'b0;
    end else if (fetch_go_r) begin
      fetch_go_r <= 1'b0;
    end else if (fetch_ok) begin
      fetch_go_r <= 1'b1;
    end
  end

  // Address register.
  // eight bit address
  always_ff @(posedge CLK_IN) begin
    if (any_rst) begin
      nvm_address_r <= '0;
    end else if (bus_wr && ap_addr_r == nac_pkg::OFS_ADDRESS) begin
      nvm_address_r <= wdata[ADDR_W-1:0];
    end
  end

  // Data byte: a finishing read loads it in the same edge that clears
  // fetch_go, and wins over a software write in that edge.
  // byte wide data
  always_ff @(posedge CLK_IN) begin
    if (any_rst) begin
      nvm_data_byte_r <= nac_pkg::RESET_BYTE;
    end else if (fetch_go_r) begin
      nvm_data_byte_r <= eeprom_mem[nvm_address_r];
    end else if (bus_wr && ap_addr_r == nac_pkg::OFS_DATA_BYTE) begin
      nvm_data_byte_r <= wdata;
    end
  end

  // Table latch and the three table pointer bytes.
  // pointer byte writes
  always_ff @(posedge CLK_IN) begin
    if (any_rst) begin
      table_latch_r <= nac_pkg::RESET_BYTE;
      table_pointer_r <= nac_pkg::RESET_POINTER;
    end else if (bus_wr) begin
      unique case (ap_addr_r)
        nac_pkg::OFS_TABLE_LATCH: table_latch_r <= wdata;
        nac_pkg::OFS_TPTR_LOW: table_pointer_r[7:0] <= wdata;
        nac_pkg::OFS_TPTR_HIGH: table_pointer_r[15:8] <= wdata;
        nac_pkg::OFS_TPTR_UPPER: table_pointer_r[20:16] <= wdata[4:0];
        default: table_latch_r <= table_latch_r;
      endcase
    end
  end

  // Completion flag: hardware set wins over a software clear in one edge.
  // set on completion
  always_ff @(posedge CLK_IN) begin
    if (any_rst) begin
      done_flag_r <= 1'b0;
    end else if (write_finish) begin
      done_flag_r <= 1'b1;
    end else if (bus_wr && ap_addr_r == nac_pkg::OFS_FLAGS_TWO) begin
      done_flag_r <= wdata[nac_pkg::BIT_DONE_FLAG];
    end
  end

  // Write sequencer: erase half, then program half, both timed internally.
  // timer governs write
  always_ff @(posedge CLK_IN) begin
    if (any_rst) begin
      state_r <= nac_pkg::ST_IDLE;
      timer_r <= 32'h00000000;
      job_flash_r <= 1'b0;
    end else begin
      unique case (state_r)
        nac_pkg::ST_IDLE: begin
          timer_r <= 32'h00000000;
          if (start_ok) begin
            state_r <= nac_pkg::ST_ERASE;
            job_flash_r <= program_sel_r | config_sel_r;
          end
        end
        nac_pkg::ST_ERASE: begin
          if (phase_end) begin
            state_r <= nac_pkg::ST_PROGRAM;
            timer_r <= 32'h00000000;
          end else begin
            timer_r <= timer_r + 32'h00000001;
          end
        end
        nac_pkg::ST_PROGRAM: begin
          if (phase_end) begin
            state_r <= nac_pkg::ST_IDLE;
            timer_r <= 32'h00000000;
          end else begin
            timer_r <= timer_r + 32'h00000001;
          end
        end
      endcase
    end
  end

  // EEPROM cells: erased at the end of the erase half, programmed at the end.
  // automatic erase first
  always_ff @(posedge CLK_IN) begin
    if (!any_rst && !job_flash_r && phase_end) begin
      if (state_r == nac_pkg::ST_ERASE) begin
        eeprom_mem[nvm_address_r] <= nac_pkg::ERASED_BYTE;
      end else begin
        eeprom_mem[nvm_address_r] <= nvm_data_byte_r;
      end
    end
  end

  // Flash or configuration request, one pulse when the write completes;
  // the pointer must already sit inside the holding-register range.
  // pointer aimed beforehand
  always_ff @(posedge CLK_IN) begin
    if (any_rst) begin
      FLASH_REQ_OUT <= '0;
    end else begin
      FLASH_REQ_OUT.valid <= write_finish & job_flash_r;
      FLASH_REQ_OUT.config_space <= config_sel_r;
      FLASH_REQ_OUT.erase_only <= erase_only_r;
      FLASH_REQ_OUT.address <= table_pointer_r;
      FLASH_REQ_OUT.data <= table_latch_r;
    end
  end

  // Core stall while a flash or configuration write runs.
  // stall during flash write
  always_ff @(posedge CLK_IN) begin
    if (any_rst) begin
      CPU_STALL_OUT <= 1'b0;
    end else if (start_ok) begin
      CPU_STALL_OUT <= program_sel_r | config_sel_r;
    end else if (write_finish) begin
      CPU_STALL_OUT <= 1'b0;
    end
  end

endmodule

// ===== include/nac_pkg.sv
package nac_pkg;

  // Byte offsets of the word-aligned registers on the AHB-Lite slave.
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_UNLOCK = 8'h04;
  localparam logic [7:0] OFS_DATA_BYTE = 8'h08;
  localparam logic [7:0] OFS_ADDRESS = 8'h0c;
  localparam logic [7:0] OFS_TABLE_LATCH = 8'h10;
  localparam logic [7:0] OFS_TPTR_LOW = 8'h14;
  localparam logic [7:0] OFS_TPTR_HIGH = 8'h18;
  localparam logic [7:0] OFS_TPTR_UPPER = 8'h1c;
  localparam logic [7:0] OFS_FLAGS_TWO = 8'h20;

  // Bit positions inside the control register.
  localparam int BIT_FETCH_GO = 0;
  localparam int BIT_PROGRAM_GO = 1;
  localparam int BIT_MODIFY_PERMIT = 2;
  localparam int BIT_ABORT_FLAG = 3;
  localparam int BIT_ERASE_ONLY = 4;
  localparam int BIT_CONFIG_SEL = 6;
  localparam int BIT_PROGRAM_SEL = 7;

  // Bit position of the completion flag in the second flag register.
  localparam int BIT_DONE_FLAG = 4;

  // Unlock key bytes, written in this order.
  localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_KEY_SECOND = 8'haa;

  // Value an erased byte holds.
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // Reset values.
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [20:0] RESET_POINTER = 21'h000000;

  // Write timing: whole write time in microseconds and the clock period.
  localparam int unsigned WRITE_TIME_US = 6000;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned WRITE_CYCLES = (WRITE_TIME_US * 1000) / CLK_PERIOD_NS;

  // Write sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ERASE,
    ST_PROGRAM
  } nac_state_e;

  // Unlock sequence progress.
  typedef enum logic [1:0] {
    UL_NONE,
    UL_FIRST,
    UL_ARMED
  } nac_unlock_e;

  // One completed program-flash or configuration write, handed to the array.
  typedef struct packed {
    logic valid;
    logic config_space;
    logic erase_only;
    logic [20:0] address;
    logic [7:0] data;
  } nac_flash_req_s;

endpackage

// ===== sim/nac_flash_model.sv
`timescale 1ns/1ps
// Stands in for the program flash and configuration arrays.
module nac_flash_model (
  // Clock.
  input wire logic clk_in,
  // Job and stall from the block.
  input wire nac_pkg::nac_flash_req_s req_in,
  input wire logic stall_in
);
  nac_pkg::nac_flash_req_s last_r; // Last job taken.
  int n_req = 0; // Jobs taken so far.
  int n_stall = 0; // Cycles the core was held.
  // The array takes each job at once, as it has no way to push back.
  always @(posedge clk_in) begin
    if (req_in.valid === 1'b1) begin
      last_r <= req_in;
      n_req <= n_req + 1;
    end
    if (stall_in === 1'b1) begin
      n_stall <= n_stall + 1;
    end
  end
endmodule

// ===== sim/nac_top_props.sv
`timescale 1ns/1ps
// Watches bus timing, readback and write sequencing at the block ports.
module nac_top_props #(
  parameter int unsigned WRITE_CYCLES = 8
) (
  // Clock and resets.
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic MASTER_CLEAR_PIN_RST_IN,
  input wire logic WATCHDOG_TIMEOUT_RST_IN,
  // Bus.
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  input wire logic [31:0] HRDATA_OUT,
  input wire logic HREADYOUT_OUT,
  // Array side.
  input wire nac_pkg::nac_flash_req_s FLASH_REQ_OUT,
  input wire logic CPU_STALL_OUT
);
  logic rst_any; // Any reset idles the block.
  logic rd_tk; // A read is taken at this edge.
  logic wr_ctl_r; // Data phase of a control write.
  logic [31:0] cnt_r; // Cycles the stall has stood.
  assign rst_any = RST_IN | MASTER_CLEAR_PIN_RST_IN | WATCHDOG_TIMEOUT_RST_IN;
  assign rd_tk = HSEL_IN & HREADY_IN & HTRANS_IN[1] & ~HWRITE_IN;
  // Remember control writes so a stall can be traced to its cause.
  always_ff @(posedge CLK_IN) begin
    if (rst_any) begin
      wr_ctl_r <= 1'b0;
    end else if (HREADY_IN) begin
      wr_ctl_r <= HSEL_IN & HTRANS_IN[1] & HWRITE_IN & (HADDR_IN[7:0] == nac_pkg::OFS_CONTROL);
    end
  end
  // A counter stands in for a long repetition, which tools unroll badly.
  always_ff @(posedge CLK_IN) begin
    if (rst_any || !CPU_STALL_OUT) begin
      cnt_r <= 32'h0;
    end else begin
      cnt_r <= cnt_r + 32'h1;
    end
  end
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (rst_any);
  a_req_one_pulse: assert property (
    FLASH_REQ_OUT.valid |=> !FLASH_REQ_OUT.valid) else $error("Array request held too long.");
  a_req_after_stall: assert property (
    FLASH_REQ_OUT.valid |-> !CPU_STALL_OUT && ($past(CPU_STALL_OUT) || $past(CPU_STALL_OUT, 2)))
    else $error("Array request without a stall before it.");
  a_stall_length: assert property (
    $fell(CPU_STALL_OUT) && !$past(rst_any) |-> cnt_r == WRITE_CYCLES)
    else $error("Stall length differs from the write time.");
  a_stall_cause: assert property (
    $rose(CPU_STALL_OUT) |-> $past(wr_ctl_r & HWDATA_IN[nac_pkg::BIT_PROGRAM_GO]))
    else $error("Stall began without a write start.");
  a_read_one_wait: assert property (
    rd_tk |=> !HREADYOUT_OUT ##1 HREADYOUT_OUT) else $error("Read wait state wrong.");
  a_unlock_reads_zero: assert property (
    rd_tk && HADDR_IN[7:0] == nac_pkg::OFS_UNLOCK |-> ##2 HRDATA_OUT == 32'h0)
    else $error("Unlock register read not zero.");
  a_upper_bits_zero: assert property (
    rd_tk |-> ##2 HRDATA_OUT[31:8] == 24'h0) else $error("Read data above a byte.");
  a_ctl_bit5_zero: assert property (
    rd_tk && HADDR_IN[7:0] == nac_pkg::OFS_CONTROL |-> ##2 !HRDATA_OUT[5])
    else $error("Control bit 5 read as one.");
endmodule
bind nac_top nac_top_props #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (
  .CLK_IN(CLK_IN), .RST_IN(RST_IN), .MASTER_CLEAR_PIN_RST_IN(MASTER_CLEAR_PIN_RST_IN),
  .WATCHDOG_TIMEOUT_RST_IN(WATCHDOG_TIMEOUT_RST_IN), .HSEL_IN(HSEL_IN), .HADDR_IN(HADDR_IN),
  .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN), .HWDATA_IN(HWDATA_IN), .HREADY_IN(HREADY_IN),
  .HRDATA_OUT(HRDATA_OUT), .HREADYOUT_OUT(HREADYOUT_OUT), .FLASH_REQ_OUT(FLASH_REQ_OUT),
  .CPU_STALL_OUT(CPU_STALL_OUT)
);

// ===== sim/test_nvm_access_control.sv
`timescale 1ns/1ps
module test_nvm_access_control;
  // Short names for the register offsets.
  localparam logic [7:0] RC = nac_pkg::OFS_CONTROL;
  localparam logic [7:0] RU = nac_pkg::OFS_UNLOCK;
  localparam logic [7:0] RD = nac_pkg::OFS_DATA_BYTE;
  localparam logic [7:0] RA = nac_pkg::OFS_ADDRESS;
  localparam logic [7:0] RF = nac_pkg::OFS_FLAGS_TWO;
  logic clk, rst, master_clear_pin, wdt, hsel, hwrite, hready, hresp, stall;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  nac_pkg::nac_flash_req_s req;
  int n_errors = 0;
  int comparisons = 0;
  int seed;
  logic [7:0] a, d, sel;
  logic [20:0] p;
  logic [7:0] aa [3];
  logic [7:0] dd [3];
  // Short write time keeps the run brief.
  nac_top #(.WRITE_CYCLES(8), .ADDR_W(8)) uut (
    .CLK_IN(clk), .RST_IN(rst), .MASTER_CLEAR_PIN_RST_IN(master_clear_pin), .WATCHDOG_TIMEOUT_RST_IN(wdt),
    .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2),
    .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready),
    .HRESP_OUT(hresp), .FLASH_REQ_OUT(req), .CPU_STALL_OUT(stall));
  nac_flash_model far (.clk_in(clk), .req_in(req), .stall_in(stall));
  // Expected control byte from select bits, permit, abort and start.
  function automatic logic [7:0] ctl(logic [7:0] s, logic pm, logic ab, logic g);
    return s | {4'h0, ab, pm, g, 1'b0};
  endfunction
  task automatic give_verdict;
    $display("Counts: %0d comparisons, %0d errors", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One single transfer; the master holds each phase until ready is seen.
  task automatic xfer(input logic w, input logic [7:0] ad, input logic [7:0] wd, output logic [31:0] q);
    int n;
    n = 0;
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, ad};
    do @(posedge clk); while (hready !== 1'b1 && ++n < 40);
    htrans <= 2'h0; hwdata <= {24'h0, wd};
    do @(posedge clk); while (hready !== 1'b1 && ++n < 40);
    q = hrdata;
    // The slave never signals an error, so every completed transfer is OKAY.
    chk("response", {31'h0, hresp}, 32'h0);
    if (n >= 40) begin
      n_errors++;
      give_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
    logic [31:0] q;
    xfer(1'b1, ad, wd, q);
  endtask
  task automatic rdc(input string nm, input logic [7:0] ad, input logic [7:0] e);
    logic [31:0] q;
    xfer(1'b0, ad, 8'h00, q);
    chk(nm, q, {24'h0, e});
  endtask
  // Unlock keys, then the start write to control.
  task automatic go(input logic [7:0] c);
    wr(RU, nac_pkg::UNLOCK_KEY_FIRST);
    wr(RU, nac_pkg::UNLOCK_KEY_SECOND);
    wr(RC, c);
  endtask
  // Poll the start bit until hardware clears it, under a bound.
  task automatic wait_done;
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      xfer(1'b0, RC, 8'h00, q);
      n++;
    end while (q[1] !== 1'b0 && n < 30);
    chk("write ends", {31'h0, q[1]}, 32'h0);
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
  initial begin
    rst = 1'b1; master_clear_pin = 1'b0; wdt = 1'b0; hsel = 1'b0; haddr = 32'h0;
    htrans = 2'h0; hwrite = 1'b0; hwdata = 32'h0;
    seed = $urandom(54775);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc("control reset", RC, 8'h00);
    rdc("unlock", RU, 8'h00);
    wr(RC, 8'h20);
    rdc("bit 5", RC, 8'h00);
    $display("Test reset values done");
    // Byte writes at both ends of the range and one in between.
    for (int i = 0; i < 3; i++) begin
      a = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom_range(254, 1));
      d = 8'($urandom);
      aa[i] = a;
      dd[i] = d;
      wr(RA, a); wr(RD, d); wr(RC, 8'h04);
      go(8'h06);
      rdc("running", RC, ctl(8'h00, 1'b1, 1'b1, 1'b1));
      wait_done();
      rdc("finished", RC, ctl(8'h00, 1'b1, 1'b0, 1'b0));
      rdc("done flag", RF, 8'h10);
      wr(RF, 8'h00);
      rdc("flag cleared", RF, 8'h00);
      wr(RD, ~d); wr(RC, 8'h05);
      rdc("fetched", RD, d);
      rdc("fetch cleared", RC, 8'h04);
    end
    for (int i = 0; i < 3; i++) begin
      wr(RA, aa[i]); wr(RC, 8'h05);
      rdc("kept", RD, dd[i]);
    end
    $display("Test data writes done");
    wr(RU, 8'haa); wr(RU, 8'h55); wr(RC, 8'h06);
    rdc("wrong order", RC, 8'h04);
    wr(RC, 8'h06);
    rdc("no unlock", RC, 8'h04);
    wr(RC, 8'h00); go(8'h02);
    rdc("no permit", RC, 8'h00);
    wr(RC, 8'h81);
    rdc("fetch refused", RC, 8'h80);
    $display("Test refusals done");
    // Program space, then configuration space.
    for (int i = 0; i < 2; i++) begin
      // The first job also asks for an erase only, so the forwarded bit is seen both ways.
      sel = (i == 0) ? 8'h90 : 8'hc0;
      p = 21'($urandom);
      d = 8'($urandom);
      wr(nac_pkg::OFS_TPTR_LOW, p[7:0]); wr(nac_pkg::OFS_TPTR_HIGH, p[15:8]);
      wr(nac_pkg::OFS_TPTR_UPPER, {3'h0, p[20:16]}); wr(nac_pkg::OFS_TABLE_LATCH, d);
      wr(RC, sel | 8'h04); go(sel | 8'h06);
      wait_done();
      repeat (3) @(posedge clk);
      chk("job count", far.n_req, 32'(i + 1));
      chk("job address", {11'h0, far.last_r.address}, {11'h0, p});
      chk("job data", {24'h0, far.last_r.data}, {24'h0, d});
      chk("job space", {31'h0, far.last_r.config_space}, 32'(i));
      chk("job erase only", {31'h0, far.last_r.erase_only}, {31'h0, sel[4]});
      chk("stall cycles", far.n_stall, 32'(8 * (i + 1)));
    end
    $display("Test array writes done");
    // Warm resets in mid-write, then a power reset.
    for (int i = 0; i < 2; i++) begin
      wr(RC, 8'h04); go(8'h06);
      repeat (2) @(posedge clk);
      if (i == 0) master_clear_pin <= 1'b1;
      else wdt <= 1'b1;
      repeat (2) @(posedge clk);
      master_clear_pin <= 1'b0; wdt <= 1'b0;
      @(posedge clk);
      rdc("abort kept", RC, 8'h08);
    end
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc("power reset", RC, 8'h00);
    $display("Test resets done");
    give_verdict();
  end
endmodule
